// ===== flash_cmd_decoder.sv
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Opcode 4B, four dummy bytes, then 128-bit fixed ID streams until deselect.
// - Four-wire ID read uses 4, 6 or 8 dummy clocks from select field.
// - Opcode 5A with 24-bit address; low byte picks start in 256-byte table.
// - Four-wire table read uses the configured 4, 6 or 8 dummy clocks.
// - Lock bits protect only with individual select set; else complement and level.
// - Lock bits are volatile and all set to 1 after any reset.
// - Opcode 36 plus address, then deselect, sets that region's lock bit.
// - Opcode 39 plus address, then deselect, clears that region's lock bit.
// - Opcode 3D plus address returns the lock bit in the least significant position.
// - Opcode 7E sets all lock bits, 98 clears all, on deselect.
// - Opcode 75 or B0 suspends program or erase; other regions stay readable.
// - Program suspend rejects status writes, security erase/program, erases, page programs.
// - Erase suspend rejects status writes, security erase and all erases.
// - Suspend taken only with suspend flag 0 and in-progress 1; else ignored.
// - Accepted suspend sets flag at once, clears in-progress within latency limit.
// - Power loss during suspend resets device out of suspended state.
// - Resume 7A or 30 taken only with suspend 1 and in-progress 0.
// - Accepted resume clears suspend at once, sets in-progress within 200 ns.
// - Dummy select resets to 8 clocks; codes 00,01 give 4, 10 six, 11 eight.
module flash_cmd_decoder
  import flash_cmd_pkg::*;
#(
  parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210 // arbitrary
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe
);
  // ==========================================================
  // Configuration and state
  logic four_wire_command_mode;
  logic individual_protect_select;
  logic protect_complement;
  logic [4:0] block_protect_level;
  logic [1:0] dummy_sel;
  logic suspend_flag;
  logic in_progress_flag;
  logic op_erase;
  logic rejected;
  logic [23:0] engine_addr;
  logic [LOCK_BITS-1:0] lock;
  logic [7:0] ptab [256];
  logic halting;
  logic resuming;
  logic [7:0] wait_cnt;

  function automatic logic [5:0] lock_index(input logic [23:0] a);
    logic [3:0] blk;
    blk = a[19:16];
    if (blk == 4'h0) begin
      lock_index = {2'b00, a[15:12]};
    end else if (blk == 4'hF) begin
      lock_index = 6'(30 + a[15:12]);
    end else begin
      lock_index = 6'(15 + blk);
    end
  endfunction

  function automatic logic prog_blocked(input logic [7:0] op);
    prog_blocked = op inside {OP_WRSR_1, OP_WRSR_2, OP_WRSR_3, OP_SEC_ERASE, OP_SEC_PROG,
                              OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_CHIP_ERASE_A,
                              OP_CHIP_ERASE_B, OP_PAGE_PROG, OP_QUAD_PROG};
  endfunction

  function automatic logic erase_blocked(input logic [7:0] op);
    erase_blocked = op inside {OP_WRSR_1, OP_WRSR_2, OP_WRSR_3, OP_SEC_ERASE, OP_ERASE_4K,
                               OP_ERASE_32K, OP_ERASE_64K, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [1:0] sclk_sync;
  logic [1:0] cs_sync;
  logic [3:0] io_meta;
  logic [3:0] io_s;
  logic sclk_d;
  logic sel_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_sync <= 2'b00;
      cs_sync <= 2'b11;
      io_meta <= 4'h0;
      io_s <= 4'h0;
      sclk_d <= 1'b0;
      sel_d <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], sclk};
      cs_sync <= {cs_sync[0], cs_n};
      io_meta <= io_in;
      io_s <= io_meta;
      sclk_d <= sclk_sync[1];
      sel_d <= ~cs_sync[1];
    end
  end
  logic sel;
  logic sck_rise;
  logic sck_fall;
  logic deselect;
  assign sel = ~cs_sync[1];
  assign sck_rise = sel && sclk_sync[1] && !sclk_d;
  assign sck_fall = sel && !sclk_sync[1] && sclk_d;
  assign deselect = sel_d && !sel;

  // ==========================================================
  // Link command sequencer
  link_state_e state;
  logic [7:0] opcode;
  logic [23:0] shreg;
  logic [23:0] addr;
  logic [5:0] cnt;
  logic [5:0] dummy_target;
  logic [2:0] opos;
  logic [7:0] oidx;
  logic [23:0] next_shreg;
  logic [5:0] cmd_clocks;
  logic [5:0] addr_clocks;
  logic [5:0] quad_dummy;
  logic [7:0] cur_byte;
  logic link_reject;

  assign next_shreg = four_wire_command_mode ? {shreg[19:0], io_s} : {shreg[22:0], io_s[0]};
  assign cmd_clocks = four_wire_command_mode ? CMD_CLK_QUAD : CMD_CLK_SINGLE;
  assign addr_clocks = four_wire_command_mode ? ADDR_CLK_QUAD : ADDR_CLK_SINGLE;
  assign quad_dummy = (dummy_sel == 2'b10) ? DUMMY_CODE_6 :
                      (dummy_sel == 2'b11) ? DUMMY_CODE_8 : DUMMY_CODE_4;

  always_comb begin
    case (opcode)
      OP_UNIQUE_ID: cur_byte = UNIQUE_ID[{~oidx[3:0], 3'b000} +: 8];
      OP_PARAM_READ: cur_byte = ptab[oidx];
      OP_LOCK_READ: cur_byte = {7'h00, lock[lock_index(addr)]};
      default: cur_byte = 8'h00;
    endcase
  end

  assign link_reject = (state == ST_CMD) && sck_rise && (cnt == cmd_clocks - 6'h01) &&
                       suspend_flag && (op_erase ? erase_blocked(next_shreg[7:0])
                                                 : prog_blocked(next_shreg[7:0]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_CMD;
      opcode <= 8'h00;
      shreg <= 24'h000000;
      addr <= 24'h000000;
      cnt <= 6'h00;
      dummy_target <= 6'h00;
    end else if (!sel) begin
      state <= ST_CMD;
      cnt <= 6'h00;
    end else if (sck_rise) begin
      shreg <= next_shreg;
      cnt <= cnt + 6'h01;
      case (state)
        ST_CMD: begin
          if (cnt == cmd_clocks - 6'h01) begin
            opcode <= next_shreg[7:0];
            cnt <= 6'h00;
            case (next_shreg[7:0])
              // ID read goes straight to dummy phase
              OP_UNIQUE_ID: begin
                state <= ST_DUMMY;
                dummy_target <= four_wire_command_mode ? quad_dummy : UID_DUMMY_SINGLE;
              end
              OP_PARAM_READ, OP_LOCK, OP_UNLOCK, OP_LOCK_READ: state <= ST_ADDR;
              default: state <= ST_WAIT;
            endcase
          end
        end
        ST_ADDR: begin
          if (cnt == addr_clocks - 6'h01) begin
            addr <= next_shreg;
            cnt <= 6'h00;
            case (opcode)
              OP_PARAM_READ: begin
                state <= ST_DUMMY;
                dummy_target <= four_wire_command_mode ? quad_dummy : PARAM_DUMMY_SINGLE;
              end
              OP_LOCK_READ: state <= ST_OUT;
              default: state <= ST_WAIT;
            endcase
          end
        end
        ST_DUMMY: begin
          if (cnt == dummy_target - 6'h01) begin
            state <= ST_OUT;
          end
        end
        ST_OUT: state <= ST_OUT;
        ST_WAIT: state <= ST_WAIT;
        default: state <= ST_CMD;
      endcase
    end
  end

  // Output shifter, updated on falling link clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
      opos <= 3'h0;
      oidx <= 8'h00;
    end else if (!sel || state != ST_OUT) begin
      io_oe <= 4'h0;
      opos <= 3'h0;
      // start byte from low address bits
      oidx <= (opcode == OP_PARAM_READ) ? addr[7:0] : 8'h00;
    end else if (sck_fall) begin
      // most significant bit first on falling edges
      if (four_wire_command_mode) begin
        io_out <= opos[2] ? cur_byte[3:0] : cur_byte[7:4];
        io_oe <= 4'hF;
        opos <= opos + 3'h4;
      end else begin
        io_out <= {2'b00, cur_byte[~opos], 1'b0};
        io_oe <= 4'h2;
        opos <= opos + 3'h1;
      end
      if (four_wire_command_mode ? opos[2] : (opos == 3'h7)) begin
        oidx <= oidx + 8'h01;
      end
    end
  end

  // Commands completed at deselect
  logic do_lock;
  logic do_unlock;
  logic do_glock;
  logic do_gunlock;
  logic do_suspend;
  logic do_resume;
  logic [5:0] cmd_idx;
  assign do_lock = deselect && state == ST_WAIT && opcode == OP_LOCK;
  assign do_unlock = deselect && state == ST_WAIT && opcode == OP_UNLOCK;
  assign do_glock = deselect && state == ST_WAIT && opcode == OP_GLOBAL_LOCK;
  assign do_gunlock = deselect && state == ST_WAIT && opcode == OP_GLOBAL_UNLOCK;
  assign do_suspend = deselect && state == ST_WAIT &&
                      (opcode == OP_SUSPEND_A || opcode == OP_SUSPEND_B);
  assign do_resume = deselect && state == ST_WAIT &&
                     (opcode == OP_RESUME_A || opcode == OP_RESUME_B);
  assign cmd_idx = lock_index(addr);

  // ==========================================================
  // Lock bits
  for (genvar i = 0; i < LOCK_BITS; i++) begin : g_lock
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lock[i] <= 1'b1;
      end else if (do_glock || (do_lock && cmd_idx == 6'(i))) begin
        lock[i] <= 1'b1;
      end else if (do_gunlock || (do_unlock && cmd_idx == 6'(i))) begin
        lock[i] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Program/erase engine
  logic apb_wr;
  logic eng_start;
  logic eng_done;
  logic start_prot;
  logic start_ok;
  logic sus_ok;
  logic res_ok;
  assign apb_wr = psel && penable && pwrite;
  assign eng_start = apb_wr && paddr == ENGINE_OFS &&
                     (pwdata[ENG_PROG_BIT] || pwdata[ENG_ERASE_BIT]);
  assign eng_done = apb_wr && paddr == ENGINE_OFS && pwdata[ENG_DONE_BIT];
  assign start_prot = individual_protect_select ? lock[lock_index(engine_addr)]
                                                : ((block_protect_level != 5'h00) ^
                                                   protect_complement);
  assign start_ok = eng_start && !start_prot && !in_progress_flag && !suspend_flag &&
                    !resuming;
  assign sus_ok = do_suspend && !suspend_flag && in_progress_flag;
  assign res_ok = do_resume && suspend_flag && !in_progress_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspend_flag <= 1'b0;
      in_progress_flag <= 1'b0;
      op_erase <= 1'b0;
      halting <= 1'b0;
      resuming <= 1'b0;
      wait_cnt <= 8'h00;
    end else begin
      if (start_ok) begin
        in_progress_flag <= 1'b1;
        op_erase <= pwdata[ENG_ERASE_BIT];
      end else if (eng_done && in_progress_flag && !halting) begin
        in_progress_flag <= 1'b0;
      end
      // flag at once, halt within latency
      if (sus_ok) begin
        suspend_flag <= 1'b1;
        halting <= 1'b1;
        wait_cnt <= SUSPEND_CYC - 8'h01;
      end else if (res_ok) begin
        // clear flag, restart within 200 ns
        suspend_flag <= 1'b0;
        resuming <= 1'b1;
        wait_cnt <= RESUME_CYC - 8'h01;
      end else if (halting || resuming) begin
        wait_cnt <= wait_cnt - 8'h01;
        if (wait_cnt == 8'h01) begin
          halting <= 1'b0;
          resuming <= 1'b0;
          in_progress_flag <= resuming;
        end
      end
    end
  end

  // ==========================================================
  // APB slave
  logic apb_setup;
  logic hit;
  logic in_ptab;
  logic [31:0] rd_val;
  logic rej_set;
  assign apb_setup = psel && !penable;
  assign in_ptab = paddr[11:10] == PARAM_WIN;
  assign hit = in_ptab || paddr inside {CONFIG_OFS, STATUS_OFS, ENGINE_OFS, ENGINE_ADDR_OFS,
                                        LOCK_LO_OFS, LOCK_HI_OFS};
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign rej_set = link_reject || (eng_start && !start_ok);

  always_comb begin
    rd_val = 32'h0000_0000;
    if (in_ptab) begin
      rd_val[7:0] = ptab[paddr[9:2]];
    end else begin
      case (paddr)
        CONFIG_OFS: begin
          rd_val[CFG_QUAD_BIT] = four_wire_command_mode;
          rd_val[CFG_IPS_BIT] = individual_protect_select;
          rd_val[CFG_CMP_BIT] = protect_complement;
          rd_val[CFG_BP_LSB +: 5] = block_protect_level;
          rd_val[CFG_DUMMY_LSB +: 2] = dummy_sel;
        end
        STATUS_OFS: begin
          rd_val[ST_SUS_BIT] = suspend_flag;
          rd_val[ST_WIP_BIT] = in_progress_flag;
          rd_val[ST_ERASE_BIT] = op_erase;
          rd_val[ST_REJ_BIT] = rejected;
          rd_val[ST_SEL_BIT] = sel;
        end
        ENGINE_ADDR_OFS: rd_val[23:0] = engine_addr;
        LOCK_LO_OFS: rd_val = lock[31:0];
        LOCK_HI_OFS: rd_val[LOCK_BITS-33:0] = lock[LOCK_BITS-1:32];
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      four_wire_command_mode <= 1'b0;
      individual_protect_select <= 1'b0;
      protect_complement <= 1'b0;
      block_protect_level <= 5'h00;
      dummy_sel <= DUMMY_SEL_RESET;
      engine_addr <= 24'h000000;
    end else if (apb_wr && paddr == CONFIG_OFS) begin
      four_wire_command_mode <= pwdata[CFG_QUAD_BIT];
      individual_protect_select <= pwdata[CFG_IPS_BIT];
      protect_complement <= pwdata[CFG_CMP_BIT];
      block_protect_level <= pwdata[CFG_BP_LSB +: 5];
      dummy_sel <= pwdata[CFG_DUMMY_LSB +: 2];
    end else if (apb_wr && paddr == ENGINE_ADDR_OFS) begin
      engine_addr <= pwdata[23:0];
    end
  end

  // Rejection flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rejected <= 1'b0;
    end else if (rej_set) begin
      rejected <= 1'b1;
    end else if (apb_wr && paddr == STATUS_OFS && pwdata[ST_REJ_BIT]) begin
      rejected <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 256; k++) begin
        ptab[k] <= PARAM_RESET;
      end
    end else if (apb_wr && in_ptab) begin
      ptab[paddr[9:2]] <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Checks
  localparam int sus_max = 39;
  localparam int res_max = 7;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence resume_taken;
    res_ok ##1 !suspend_flag;
  endsequence

  suspend_set_a: assert property (sus_ok |=> suspend_flag)
    else $error("suspend flag not set after accepted suspend");
  halt_latency_a: assert property ($rose(suspend_flag) |-> ##[1:sus_max] !in_progress_flag)
    else $error("in-progress not cleared within suspend latency");
  suspend_ignore_a: assert property (do_suspend && !sus_ok && !res_ok |=> $stable(suspend_flag))
    else $error("ignored suspend changed suspend flag");
  resume_rise_a: assert property (resume_taken |-> ##[0:res_max] in_progress_flag)
    else $error("in-progress not raised within 200 ns of resume");
  resume_ignore_a: assert property (do_resume && !res_ok |=> suspend_flag == $past(suspend_flag))
    else $error("ignored resume changed suspend flag");
  global_lock_a: assert property (do_glock |=> &lock)
    else $error("global lock left a bit clear");
  unlock_one_a: assert property (do_unlock && !do_glock |=> !lock[$past(cmd_idx)])
    else $error("unlock did not clear addressed bit");
  reject_flag_a: assert property (link_reject |=> rejected)
    else $error("blocked opcode under suspend not flagged");
  release_pins_a: assert property (!sel |=> io_oe == 4'h0)
    else $error("output still driven after deselect");
endmodule

// ===== flash_cmd_pkg.sv
package flash_cmd_pkg;
  // ==========================================================
  // Serial command opcodes
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
  localparam logic [7:0] OP_PARAM_READ = 8'h5A;
  localparam logic [7:0] OP_LOCK = 8'h36;
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_LOCK_READ = 8'h3D;
  localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_SUSPEND_A = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
  localparam logic [7:0] OP_RESUME_A = 8'h7A;
  localparam logic [7:0] OP_RESUME_B = 8'h30;
  localparam logic [7:0] OP_WRSR_1 = 8'h01;
  localparam logic [7:0] OP_WRSR_2 = 8'h31;
  localparam logic [7:0] OP_WRSR_3 = 8'h11;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  // ==========================================================
  // Link framing in clocks
  localparam logic [5:0] CMD_CLK_SINGLE = 6'h08;
  localparam logic [5:0] CMD_CLK_QUAD = 6'h02;
  localparam logic [5:0] ADDR_CLK_SINGLE = 6'h18;
  localparam logic [5:0] ADDR_CLK_QUAD = 6'h06;
  localparam logic [5:0] UID_DUMMY_SINGLE = 6'h20;
  localparam logic [5:0] PARAM_DUMMY_SINGLE = 6'h08;
  localparam logic [5:0] DUMMY_CODE_4 = 6'h04;
  localparam logic [5:0] DUMMY_CODE_6 = 6'h06;
  localparam logic [5:0] DUMMY_CODE_8 = 6'h08;
  localparam int LOCK_BITS = 46;
  // ==========================================================
  // Register map
  localparam logic [11:0] CONFIG_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] ENGINE_OFS = 12'h008;
  localparam logic [11:0] ENGINE_ADDR_OFS = 12'h00C;
  localparam logic [11:0] LOCK_LO_OFS = 12'h010;
  localparam logic [11:0] LOCK_HI_OFS = 12'h014;
  localparam logic [1:0] PARAM_WIN = 2'h1;
  localparam int CFG_QUAD_BIT = 0;
  localparam int CFG_IPS_BIT = 1;
  localparam int CFG_CMP_BIT = 2;
  localparam int CFG_BP_LSB = 3;
  localparam int CFG_DUMMY_LSB = 8;
  localparam int ST_SUS_BIT = 0;
  localparam int ST_WIP_BIT = 1;
  localparam int ST_ERASE_BIT = 2;
  localparam int ST_REJ_BIT = 3;
  localparam int ST_SEL_BIT = 4;
  localparam int ENG_PROG_BIT = 0;
  localparam int ENG_ERASE_BIT = 1;
  localparam int ENG_DONE_BIT = 2;
  localparam logic [1:0] DUMMY_SEL_RESET = 2'h3;
  localparam logic [7:0] PARAM_RESET = 8'hFF;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SUSPEND_LATENCY_LIMIT_NS = 1000;
  localparam int RESUME_LIMIT_NS = 200;
  localparam logic [7:0] SUSPEND_CYC = 8'(SUSPEND_LATENCY_LIMIT_NS / CLK_PERIOD_NS);
  localparam logic [7:0] RESUME_CYC = 8'(RESUME_LIMIT_NS / CLK_PERIOD_NS);
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_OUT, ST_WAIT} link_state_e;
endpackage

// ===== host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
  input wire logic pclk,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end
  // ==========================================================
  // Single- or four-wire frame, clock idle low, 8 pclk period
  // select, opcode, operands, deselect
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                       output logic [127:0] rx, input bit quad = 1'b0);
    logic [3:0] line;
    rx = '0;
    @(posedge pclk);
    cs_n <= 1'b0;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < ntx + nrx; i++) begin
      sclk <= 1'b0;
      if (i >= ntx) io_in <= ~io_in;
      else if (quad) io_in <= tx[4*(ntx-1-i) +: 4];
      else io_in[0] <= tx[ntx-1-i];
      repeat (4) @(posedge pclk);
      sclk <= 1'b1;
      repeat (4) @(posedge pclk);
      // Undriven lines read back inverted
      line = io_out ~^ io_oe;
      if (i >= ntx) rx = quad ? {rx[123:0], line} : {rx[126:0], line[1]};
    end
    sclk <= 1'b0;
    repeat (4) @(posedge pclk);
    cs_n <= 1'b1;
    io_in <= ~io_in;
    repeat (16) @(posedge pclk);
  endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb import flash_cmd_pkg::*;;
  localparam logic [127:0] ID_VAL = 128'hC3A5_0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2; // arbitrary
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sclk, cs_n, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0] io_in, io_out, io_oe;
  logic [127:0] rx;
  logic [23:0] a;
  logic [45:0] lk;
  logic [7:0] v [2];
  logic [1:0] ds;
  int dc;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int idx;

  flash_cmd_decoder #(.UNIQUE_ID(ID_VAL)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));
  host_link_model host (.pclk(pclk), .io_out(io_out), .io_oe(io_oe), .sclk(sclk),
    .cs_n(cs_n), .io_in(io_in));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================================
  // Bench tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st();
    apb(1'b0, STATUS_OFS, 32'h0, d, e);
  endtask
  task automatic read_locks(output logic [45:0] lv);
    logic [31:0] lo, hi;
    logic err;
    apb(1'b0, LOCK_LO_OFS, 32'h0, lo, err);
    apb(1'b0, LOCK_HI_OFS, 32'h0, hi, err);
    lv = {hi[13:0], lo};
  endtask
  function automatic int lock_index(input logic [23:0] ad);
    if (ad[19:16] == 4'h0) return int'(ad[15:12]);
    if (ad[19:16] == 4'hF) return 30 + int'(ad[15:12]);
    return 15 + int'(ad[19:16]);
  endfunction
  function automatic int dummy_clocks(input logic [1:0] s);
    return (s == 2'b10) ? 6 : (s == 2'b11) ? 8 : 4;
  endfunction

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      conclude();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(32'h1a335c3b));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, CONFIG_OFS, 32'h0, d, e);
    check("config", d, 32'h300);
    read_locks(lk);
    check("reset locks", lk, {46{1'b1}});
    apb(1'b0, 12'hFF0, 32'h0, d, e);
    check("unmapped", {e, d}, {1'b1, 32'h0});
    host.frame({8'h4B, 32'h0}, 40, 128, rx);
    check("unique id", rx, ID_VAL);
    for (int k = 0; k < 2; k++) begin
      a[7:0] = k ? 8'($urandom) : 8'hFF;
      for (int j = 0; j < 2; j++) begin
        v[j] = 8'($urandom);
        apb(1'b1, {2'b01, 8'(a[7:0] + 8'(j)), 2'b00}, {24'h0, v[j]}, d, e);
      end
      host.frame({8'h5A, 16'h0, a[7:0], 8'h0}, 40, 16, rx);
      check("table", rx, {v[0], v[1]});
    end
    for (int k = 0; k < 3; k++) begin
      ds = (k == 0) ? 2'b10 : (k == 1) ? 2'b01 : 2'($urandom);
      dc = dummy_clocks(ds);
      apb(1'b1, CONFIG_OFS, {22'h0, ds, 8'h01}, d, e);
      host.frame(64'(8'h4B) << (4 * dc), 2 + dc, 32, rx, 1'b1);
      check("quad id", rx, ID_VAL);
      host.frame(64'({8'h5A, 16'h0, a[7:0]}) << (4 * dc), 8 + dc, 4, rx, 1'b1);
      check("quad table", rx, {v[0], v[1]});
    end
    apb(1'b1, CONFIG_OFS, 32'h300, d, e);
    host.frame(8'h98, 8, 0, rx);
    read_locks(lk);
    check("unlock all", lk, 0);
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? 24'h0FF000 : {4'h0, 20'($urandom)};
      idx = lock_index(a);
      host.frame({8'h36, a}, 32, 0, rx);
      read_locks(lk);
      check("lock one", lk, 46'(1) << idx);
      host.frame({8'h3D, a}, 32, 8, rx);
      check("lock read", rx, 1);
      host.frame({8'h39, a}, 32, 0, rx);
      read_locks(lk);
      check("unlock one", lk, 0);
      host.frame({8'h3D, a}, 32, 8, rx);
      check("lock read", rx, 0);
    end
    host.frame(8'h7E, 8, 0, rx);
    read_locks(lk);
    check("lock all", lk, {46{1'b1}});
    apb(1'b1, CONFIG_OFS, 32'h302, d, e);
    apb(1'b1, ENGINE_OFS, 32'h1, d, e);
    st();
    check("protected", d[3:1], 3'b100);
    apb(1'b1, STATUS_OFS, 32'h8, d, e);
    apb(1'b1, CONFIG_OFS, 32'h300, d, e);
    host.frame(8'h75, 8, 0, rx);
    st();
    check("idle suspend", d[1:0], 2'b00);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, ENGINE_ADDR_OFS, {12'h0, 20'($urandom)}, d, e);
      apb(1'b1, ENGINE_OFS, 32'(1 << k), d, e);
      host.frame(k ? 8'h7A : 8'h30, 8, 0, rx);
      st();
      check("busy", d[2:0], k ? 3'b110 : 3'b010);
      host.frame(k ? 8'hB0 : 8'h75, 8, 0, rx);
      st();
      check("suspend flag", d[0], 1);
      // host waits out the latency limit
      repeat (SUSPEND_CYC) @(posedge pclk);
      st();
      check("halted", d[2:0], k ? 3'b101 : 3'b001);
      host.frame({k ? 8'h20 : 8'h02, a}, 32, 0, rx);
      st();
      check("refused", d[3], 1);
      apb(1'b1, STATUS_OFS, 32'h8, d, e);
      host.frame(k ? 8'h30 : 8'h7A, 8, 0, rx);
      st();
      check("resumed", d[3:0], k ? 4'b0110 : 4'b0010);
      apb(1'b1, ENGINE_OFS, 32'h4, d, e);
      st();
      check("finished", d[1:0], 2'b00);
    end
    host.frame(8'h98, 8, 0, rx);
    apb(1'b1, ENGINE_OFS, 32'h1, d, e);
    host.frame(8'h75, 8, 0, rx);
    st();
    check("suspend before reset", d[0], 1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    st();
    check("reset suspend", d[1:0], 2'b00);
    read_locks(lk);
    check("reset relock", lk, {46{1'b1}});
    conclude();
  end
endmodule
